// File: rtl/dft_pkg.sv
// package: types and constants for the deferred fault token logic
package dft_pkg;
    localparam int DFT_XLEN       = 64;
    localparam int DFT_GR_WIDTH   = 65;
    localparam int DFT_FR_WIDTH   = 82;
    localparam int DFT_EXC_WIDTH  = 4;
    // fp token: exponent field all-ones minus one, zero significand; encoding kept as one constant
    localparam logic [81:0] DFT_FP_TOKEN = 82'h1FFFE0000000000000000;
    localparam logic [DFT_EXC_WIDTH-1:0] DFT_DEFER_MASK_RESET = 4'hF;
    localparam logic [63:0] DFT_ZERO_DATA = 64'h0;

    typedef enum logic [3:0] {
        DFT_OP_NOP,
        DFT_OP_INT_LOAD,
        DFT_OP_FP_LOAD,
        DFT_OP_FP_PAIR_LOAD,
        DFT_OP_SPEC_INT_LOAD,
        DFT_OP_SPEC_FP_LOAD,
        DFT_OP_SPEC_FP_PAIR_LOAD,
        DFT_OP_COMPUTE,
        DFT_OP_NONSPEC_OTHER,
        DFT_OP_SPEC_CHECK,
        DFT_OP_PRED_WRITE,
        DFT_OP_FLAG_TEST,
        DFT_OP_FP_CLASS
    } dft_op_t;

    typedef struct packed {
        logic                      valid;
        dft_op_t                   op;
        logic                      src_a_fp;
        logic                      src_b_fp;
        logic [DFT_FR_WIDTH-1:0]   src_a;
        logic [DFT_FR_WIDTH-1:0]   src_b;
        logic                      use_b;
        logic                      dst_fp;
        logic [DFT_FR_WIDTH-1:0]   result;
        logic [DFT_EXC_WIDTH-1:0]  exc;
        logic                      ieee_exc;
        logic                      pred_clear_type;
        logic [1:0]                pred_result;
        logic                      class_tests_token;
        logic [63:0]               branch_base;
        logic [63:0]               imm_offset;
    } dft_req_t;

    typedef struct packed {
        logic                      valid;
        logic                      write_dst;
        logic                      dst_fp;
        logic [DFT_FR_WIDTH-1:0]   dst_value;
        logic                      pred_write;
        logic [1:0]                pred_value;
        logic                      branch;
        logic [63:0]               branch_target;
        logic                      raise;
        logic                      poison_fault;
        logic                      sw_handle;
        logic [DFT_EXC_WIDTH-1:0]  exc;
        logic                      ieee_flag;
    } dft_rsp_t;
endpackage : dft_pkg

// File: rtl/dft_token_unit.sv
// deferred fault token generation, propagation, checks and consumption faults
`timescale 1ns/10ps
`default_nettype none

// Operation
// - integer register values are 65 bits: 64 data plus deferred_fault_flag
// - flag of 1 marks a token; data then forced to zero, never relied upon
// - fp registers mark a token by the fp_deferred_fault_pattern encoding
// - a deferred exception writes a token into the destination
// - non-speculative instructions raise exceptions immediately
// - speculative instructions never raise; they record a token
// - loads exist as int_load, fp_load, fp_pair_load and speculative forms
// - register-writing computations are speculative
// - instructions changing other state are non-speculative, special cases aside
// - speculative consumer of a token source writes a token
// - spec_check branches to base plus immediate when its register holds token
// - only speculative loads create tokens; others only propagate
// - ieee fp exceptions go to alternate status, never tokens
// - predicate writers with token source clear or keep all predicates
// - flag_test reads deferred_fault_flag and writes two predicates
// - fp_class detects the fp token, not clearing both when tested for
// - non-speculative read of a token raises poisoned_operand_use_fault
// - privileged mask selects hardware-deferred versus software-handled load faults
module dft_token_unit
    import dft_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire dft_req_t                  req,
    input  wire logic [DFT_EXC_WIDTH-1:0]  defer_mask,
    output dft_rsp_t                       rsp
);

    // int flag sits just above the data; fp values hold a whole int value plus 17 bits
    if (DFT_GR_WIDTH != DFT_XLEN + 1 || DFT_FR_WIDTH != DFT_GR_WIDTH + 17) begin : width_check_g
        $error("register widths do not fit the token layout");
    end

    function automatic logic is_token(input logic fp, input logic [DFT_FR_WIDTH-1:0] v);
        if (fp) begin
            return v == DFT_FP_TOKEN;
        end
        return v[DFT_GR_WIDTH-1];
    endfunction : is_token

    function automatic logic [DFT_FR_WIDTH-1:0] make_token(input logic fp);
        if (fp) begin
            return DFT_FP_TOKEN;
        end
        return {17'h0, 1'b1, DFT_ZERO_DATA};
    endfunction : make_token

    // privileged mask is sampled here so a change takes effect cleanly on the next op
    logic [DFT_EXC_WIDTH-1:0] defer_sel;
    always_ff @(posedge clk) begin
        if (rst) begin
            defer_sel <= DFT_DEFER_MASK_RESET;
        end else begin
            defer_sel <= defer_mask;
        end
    end

    logic src_tok;
    logic spec_load;
    logic nonspec_load;
    logic spec_cls;
    logic has_exc;
    logic hw_defer;
    always_comb begin
        src_tok = is_token(req.src_a_fp, req.src_a)
                | (req.use_b & is_token(req.src_b_fp, req.src_b));
        spec_load = req.op inside {DFT_OP_SPEC_INT_LOAD, DFT_OP_SPEC_FP_LOAD,
                                   DFT_OP_SPEC_FP_PAIR_LOAD};
        nonspec_load = req.op inside {DFT_OP_INT_LOAD, DFT_OP_FP_LOAD, DFT_OP_FP_PAIR_LOAD};
        spec_cls = spec_load | (req.op == DFT_OP_COMPUTE);
        has_exc = |req.exc;
        hw_defer = |(req.exc & defer_sel);
    end

    dft_rsp_t next_rsp;
    always_comb begin
        next_rsp = '0;
        next_rsp.valid = req.valid;
        next_rsp.dst_fp = req.dst_fp;
        next_rsp.dst_value = req.result;
        if (req.valid) begin
            unique case (req.op)
                DFT_OP_SPEC_INT_LOAD, DFT_OP_SPEC_FP_LOAD, DFT_OP_SPEC_FP_PAIR_LOAD: begin
                    next_rsp.write_dst = 1'b1;
                    if (src_tok || (has_exc && hw_defer)) begin
                        next_rsp.dst_value = make_token(req.dst_fp);
                    end else if (has_exc) begin
                        next_rsp.write_dst = 1'b0;
                        next_rsp.sw_handle = 1'b1;
                        next_rsp.exc = req.exc;
                    end
                end
                DFT_OP_COMPUTE: begin
                    next_rsp.write_dst = 1'b1;
                    // computations never create tokens, only carry them
                    if (src_tok) begin
                        next_rsp.dst_value = make_token(req.dst_fp);
                    end
                    next_rsp.ieee_flag = req.ieee_exc;
                end
                DFT_OP_INT_LOAD, DFT_OP_FP_LOAD, DFT_OP_FP_PAIR_LOAD, DFT_OP_NONSPEC_OTHER: begin
                    if (src_tok) begin
                        next_rsp.poison_fault = 1'b1;
                    end else if (has_exc) begin
                        next_rsp.raise = 1'b1;
                        next_rsp.exc = req.exc;
                    end else begin
                        next_rsp.write_dst = nonspec_load;
                    end
                end
                DFT_OP_SPEC_CHECK: begin
                    if (is_token(req.src_a_fp, req.src_a)) begin
                        next_rsp.branch = 1'b1;
                        next_rsp.branch_target = 64'(req.branch_base + req.imm_offset);
                    end
                    // no token: nothing written, falls through
                end
                DFT_OP_PRED_WRITE: begin
                    if (src_tok) begin
                        next_rsp.pred_write = req.pred_clear_type;
                        next_rsp.pred_value = 2'h0;
                    end else begin
                        next_rsp.pred_write = 1'b1;
                        next_rsp.pred_value = req.pred_result;
                    end
                end
                DFT_OP_FLAG_TEST: begin
                    next_rsp.pred_write = 1'b1;
                    next_rsp.pred_value = {~req.src_a[DFT_GR_WIDTH-1],
                                           req.src_a[DFT_GR_WIDTH-1]};
                end
                DFT_OP_FP_CLASS: begin
                    next_rsp.pred_write = 1'b1;
                    if (is_token(1'b1, req.src_a) && req.class_tests_token) begin
                        next_rsp.pred_value = 2'h1;
                    end else if (is_token(1'b1, req.src_a)) begin
                        next_rsp.pred_value = 2'h0;
                    end else begin
                        next_rsp.pred_value = req.pred_result;
                    end
                end
                default: begin
                    next_rsp.valid = req.valid;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rsp <= '0;
        end else begin
            rsp <= next_rsp;
        end
    end

    dft_req_t prev_req;
    logic     prev_tok;
    logic     prev_hw;
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_req <= '0;
            prev_tok <= 1'b0;
            prev_hw <= 1'b0;
        end else begin
            prev_req <= req;
            prev_tok <= src_tok;
            prev_hw <= hw_defer;
        end
    end

    // op classes of the instruction answered this cycle, for the checks below
    logic prev_spec_cls;
    logic prev_spec_load;
    logic prev_nonspec_load;
    logic prev_exc;
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_spec_cls <= 1'b0;
            prev_spec_load <= 1'b0;
            prev_nonspec_load <= 1'b0;
            prev_exc <= 1'b0;
        end else begin
            prev_spec_cls <= spec_cls;
            prev_spec_load <= spec_load;
            prev_nonspec_load <= nonspec_load;
            prev_exc <= has_exc;
        end
    end

    // each check looks at the answer one edge after the op was taken
    spec_no_raise_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_spec_cls |-> !rsp.raise && !rsp.poison_fault)
        else $error("speculative op raised");

    nonspec_poison_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_tok && prev_req.op == DFT_OP_NONSPEC_OTHER |-> rsp.poison_fault)
        else $error("token consumption not faulted");

    propagate_tok_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_tok && prev_req.op == DFT_OP_COMPUTE
        |-> rsp.write_dst && is_token(rsp.dst_fp, rsp.dst_value))
        else $error("token not propagated");

    no_new_tok_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && !prev_tok && prev_req.op == DFT_OP_COMPUTE
        |-> rsp.dst_value == prev_req.result)
        else $error("computation created a token");

    load_defer_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_req.op == DFT_OP_SPEC_INT_LOAD && |prev_req.exc && prev_hw
        |-> rsp.dst_value[DFT_GR_WIDTH-1] && !rsp.raise)
        else $error("speculative load fault not deferred");

    check_branch_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_req.op == DFT_OP_SPEC_CHECK
        |-> rsp.branch == is_token(prev_req.src_a_fp, prev_req.src_a)
            && !rsp.write_dst && !rsp.pred_write)
        else $error("spec_check wrong");

    pred_keep_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_tok && prev_req.op == DFT_OP_PRED_WRITE
        |-> rsp.pred_value == 2'h0 && rsp.pred_write == prev_req.pred_clear_type)
        else $error("token predicate handling wrong");

    flag_test_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_req.op == DFT_OP_FLAG_TEST |-> rsp.pred_value[0] == prev_req.src_a[DFT_GR_WIDTH-1])
        else $error("flag_test result wrong");

    nonspec_raise_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && !prev_tok && |prev_req.exc && prev_req.op == DFT_OP_INT_LOAD
        |-> rsp.raise)
        else $error("non-speculative fault not raised");

    int_tok_layout_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_spec_load && !prev_req.dst_fp && (prev_tok || (prev_exc && prev_hw))
        |-> rsp.dst_value[DFT_GR_WIDTH-1:0] == {1'b1, DFT_ZERO_DATA})
        else $error("int token layout wrong");

    fp_tok_pattern_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_spec_load && prev_req.dst_fp && (prev_tok || (prev_exc && prev_hw))
        |-> rsp.dst_value == DFT_FP_TOKEN)
        else $error("fp token pattern wrong");

    spec_load_tok_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_spec_load && prev_tok
        |-> rsp.write_dst && is_token(rsp.dst_fp, rsp.dst_value))
        else $error("load did not carry token");

    sw_handle_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_spec_load && !prev_tok && prev_exc && !prev_hw
        |-> rsp.sw_handle && !rsp.write_dst && rsp.exc == prev_req.exc)
        else $error("software-handled fault not passed on");

    spec_load_clean_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_spec_load && !prev_tok && !prev_exc
        |-> rsp.write_dst && rsp.dst_value == prev_req.result)
        else $error("clean load altered");

    load_poison_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_nonspec_load && prev_tok |-> rsp.poison_fault && !rsp.write_dst)
        else $error("load of token address not faulted");

    nonspec_exc_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && !prev_tok && prev_exc
        && (prev_nonspec_load || prev_req.op == DFT_OP_NONSPEC_OTHER)
        |-> rsp.raise && !rsp.write_dst && rsp.exc == prev_req.exc)
        else $error("immediate fault missing");

    load_write_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_nonspec_load && !prev_tok && !prev_exc
        |-> rsp.write_dst && !rsp.raise && !rsp.poison_fault)
        else $error("plain load not written");

    other_no_write_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_req.op == DFT_OP_NONSPEC_OTHER |-> !rsp.write_dst)
        else $error("non-register op wrote a register");

    compute_ieee_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_req.op == DFT_OP_COMPUTE
        |-> rsp.write_dst && rsp.ieee_flag == prev_req.ieee_exc && !rsp.sw_handle)
        else $error("ieee status handling wrong");

    check_target_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_req.op == DFT_OP_SPEC_CHECK && is_token(prev_req.src_a_fp, prev_req.src_a)
        |-> rsp.branch_target == 64'(prev_req.branch_base + prev_req.imm_offset))
        else $error("check branch target wrong");

    check_fall_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_req.op == DFT_OP_SPEC_CHECK && !is_token(prev_req.src_a_fp, prev_req.src_a)
        |-> !rsp.branch && !rsp.write_dst && !rsp.pred_write && !rsp.raise && !rsp.poison_fault)
        else $error("fall-through changed state");

    branch_only_check_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.op != DFT_OP_SPEC_CHECK |-> !rsp.branch)
        else $error("branch from a non-check op");

    pred_plain_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && !prev_tok && prev_req.op == DFT_OP_PRED_WRITE
        |-> rsp.pred_write && rsp.pred_value == prev_req.pred_result)
        else $error("predicate result lost");

    flag_pair_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_req.op == DFT_OP_FLAG_TEST
        |-> rsp.pred_write && rsp.pred_value[1] != prev_req.src_a[DFT_GR_WIDTH-1])
        else $error("flag_test complement wrong");

    class_token_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_req.op == DFT_OP_FP_CLASS && prev_req.class_tests_token
        && prev_req.src_a == DFT_FP_TOKEN |-> rsp.pred_write && rsp.pred_value != 2'h0)
        else $error("fp_class cleared both predicates");

    class_plain_a: assert property (@(posedge clk) disable iff (rst)
        prev_req.valid && prev_req.op == DFT_OP_FP_CLASS && prev_req.src_a != DFT_FP_TOKEN
        |-> rsp.pred_write && rsp.pred_value == prev_req.pred_result)
        else $error("fp_class result lost");

    // selection is registered, so a mask change shows one edge later
    mask_reset_a: assert property (@(posedge clk)
        rst |=> defer_sel == DFT_DEFER_MASK_RESET)
        else $error("defer selection not reset");

    mask_follow_a: assert property (@(posedge clk) disable iff (rst)
        !rst |=> defer_sel == $past(defer_mask))
        else $error("defer selection not following mask");

    // main scenarios worth seeing at least once
    cov_defer_c: cover property (@(posedge clk) disable iff (rst)
        rsp.valid && rsp.write_dst && is_token(rsp.dst_fp, rsp.dst_value));
    cov_branch_c: cover property (@(posedge clk) disable iff (rst) rsp.branch);
    cov_poison_c: cover property (@(posedge clk) disable iff (rst) rsp.poison_fault);
    cov_sw_c: cover property (@(posedge clk) disable iff (rst) rsp.sw_handle);
    cov_ieee_c: cover property (@(posedge clk) disable iff (rst) rsp.ieee_flag);

endmodule : dft_token_unit

`default_nettype wire

// File: verification/dft_issue_model.sv
// partner model: issue pipeline handing one instruction at a time to the token unit
`timescale 1ns/10ps
`default_nettype none
module dft_issue_model
    import dft_pkg::*;
(
    input  wire logic     clk,
    output var dft_req_t  req,
    input  wire dft_rsp_t rsp
);
    initial req = '0;
    // held across one sampling edge, answer taken one edge later
    task automatic issue(input dft_req_t r, output dft_rsp_t got);
        dft_req_t idle;
        @(negedge clk);
        req = r;
        @(negedge clk);
        got = rsp;
        // released fields show the inverse so a stale read cannot pass
        idle = ~r;
        idle.valid = 1'b0;
        req = idle;
    endtask : issue
endmodule : dft_issue_model
`default_nettype wire

// File: verification/tb_deferred_fault_token_logic.sv
// testbench: token generation, propagation, checks and faults of the token unit
`timescale 1ns/10ps
`default_nettype none
module tb_deferred_fault_token_logic
    import dft_pkg::*;
;
    localparam logic [81:0] ITOK = 82'h10000000000000000;
    logic                    clk;
    logic                    rst;
    logic [DFT_EXC_WIDTH-1:0] defer_mask;
    dft_req_t                req;
    dft_rsp_t                rsp;
    dft_rsp_t                got;
    dft_req_t                r;
    int                      miscompares;
    int                      checks;

    dft_token_unit dft_token_unit_i (.clk(clk), .rst(rst), .req(req), .defer_mask(defer_mask), .rsp(rsp));
    dft_issue_model dft_issue_model_i (.clk(clk), .req(req), .rsp(rsp));

    initial clk = 1'b0;
    always #4 clk = ~clk;

    task automatic report_and_stop();
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [81:0] seen, input logic [81:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    function automatic dft_req_t mk(input dft_op_t op);
        dft_req_t q;
        q = '0;
        q.valid = 1'b1;
        q.op = op;
        return q;
    endfunction : mk

    task automatic go();
        dft_issue_model_i.issue(r, got);
    endtask : go

    task automatic spec_loads_defer();
        dft_op_t ops[3] = '{DFT_OP_SPEC_INT_LOAD, DFT_OP_SPEC_FP_LOAD, DFT_OP_SPEC_FP_PAIR_LOAD};
        for (int i = 0; i < 3; i++) begin
            r = mk(ops[i]);
            r.exc = 4'h1;
            r.dst_fp = (i != 0);
            go();
            check({got.valid, got.dst_fp, got.raise, got.write_dst}, {1'b1, i != 0, 2'b01});
            if (i == 0) check(got.dst_value[64:0], {1'b1, DFT_ZERO_DATA});
            else check(got.dst_value, DFT_FP_TOKEN);
        end
    endtask : spec_loads_defer

    task automatic nonspec_faults();
        dft_op_t ops[4] = '{DFT_OP_INT_LOAD, DFT_OP_FP_LOAD, DFT_OP_FP_PAIR_LOAD, DFT_OP_NONSPEC_OTHER};
        for (int i = 0; i < 4; i++) begin
            r = mk(ops[i]);
            r.exc = 4'h2;
            go();
            check({got.raise, got.write_dst, got.exc}, {2'b10, 4'h2});
            r.exc = 4'h0;
            r.src_a = ITOK;
            go();
            check({got.poison_fault, got.write_dst}, 2'b10);
            r.src_a = 82'h0;
            go();
            check({got.raise, got.poison_fault, got.write_dst}, {2'b00, i != 3});
        end
    endtask : nonspec_faults

    task automatic compute_tokens();
        r = mk(DFT_OP_COMPUTE);
        r.result = 82'h5A5A;
        r.exc = 4'h1;
        r.ieee_exc = 1'b1;
        go();
        check({got.raise, got.ieee_flag, got.write_dst}, 3'b011);
        check(got.dst_value, 82'h5A5A);
        r.ieee_exc = 1'b0;
        r.use_b = 1'b1;
        r.src_b = ITOK;
        go();
        check(got.dst_value[64:0], {1'b1, DFT_ZERO_DATA});
        r.dst_fp = 1'b1;
        r.src_b_fp = 1'b1;
        r.src_b = DFT_FP_TOKEN;
        go();
        check(got.dst_value, DFT_FP_TOKEN);
    endtask : compute_tokens

    task automatic spec_check_branch();
        r = mk(DFT_OP_SPEC_CHECK);
        r.src_a = ITOK;
        r.branch_base = 64'h1000;
        r.imm_offset = 64'h40;
        go();
        check({got.branch, got.write_dst, got.branch_target}, {2'b10, 64'h1040});
        r.src_a_fp = 1'b1;
        r.src_a = DFT_FP_TOKEN;
        go();
        check(got.branch, 1'b1);
        r.src_a = 82'h77;
        go();
        check({got.branch, got.write_dst, got.pred_write, got.raise, got.poison_fault}, 5'h0);
    endtask : spec_check_branch

    task automatic predicate_tokens();
        r = mk(DFT_OP_PRED_WRITE);
        r.src_a = ITOK;
        r.pred_result = 2'b11;
        r.pred_clear_type = 1'b1;
        go();
        check({got.pred_write, got.pred_value}, 3'b100);
        r.pred_clear_type = 1'b0;
        go();
        check(got.pred_write, 1'b0);
        r.src_a = 82'h0;
        go();
        check({got.pred_write, got.pred_value}, 3'b111);
        r = mk(DFT_OP_FLAG_TEST);
        r.src_a = ITOK;
        go();
        check({got.pred_write, got.pred_value}, 3'b101);
        r.src_a = 82'h0;
        go();
        check(got.pred_value, 2'b10);
        r = mk(DFT_OP_FP_CLASS);
        r.src_a_fp = 1'b1;
        r.src_a = DFT_FP_TOKEN;
        r.class_tests_token = 1'b1;
        go();
        check(got.pred_value, 2'b01);
        r.class_tests_token = 1'b0;
        go();
        check({got.pred_write, got.pred_value}, 3'b100);
        r.src_a = 82'h77;
        r.pred_result = 2'b10;
        go();
        check({got.pred_write, got.pred_value}, 3'b110);
    endtask : predicate_tokens

    task automatic mask_selection();
        @(negedge clk);
        defer_mask = 4'hE;
        r = mk(DFT_OP_SPEC_INT_LOAD);
        r.exc = 4'h1;
        go();
        check({got.sw_handle, got.write_dst, got.raise, got.exc}, {3'b100, 4'h1});
        r.exc = 4'h2;
        go();
        check({got.sw_handle, got.write_dst}, 2'b01);
        r.exc = 4'h0;
        r.result = 82'h33;
        go();
        check({got.write_dst, got.sw_handle}, 2'b10);
        check(got.dst_value, 82'h33);
        r.exc = 4'h1;
        r.src_a = ITOK;
        go();
        check({got.write_dst, got.sw_handle, got.dst_value[64]}, 3'b101);
        defer_mask = 4'hF;
    endtask : mask_selection

    initial begin
        rst = 1'b1;
        defer_mask = 4'hF;
        miscompares = 0;
        checks = 0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        spec_loads_defer();
        nonspec_faults();
        compute_tokens();
        spec_check_branch();
        predicate_tokens();
        mask_selection();
        report_and_stop();
    end

    // about 80 cycles of traffic expected; generous margin
    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule : tb_deferred_fault_token_logic
`default_nettype wire
